// [core/fbpc_pkg.sv]
/*
  Constants, command codes and carrier types for the block protection
  command host. Assumes a x16 parallel NOR flash on the far side and
  APB software access to the host's own registers.
*/
package fbpc_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_PWLO   = 8'h0C;
  localparam logic [7:0] REG_PWHI   = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_RDLO   = 8'h18;
  localparam logic [7:0] REG_RDHI   = 8'h1C;
  // field positions
  localparam int CTRL_START_BIT = 8;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_DONE_BIT    = 1;
  localparam int ST_PROT_BIT    = 2;
  localparam int ST_ERR_BIT     = 3;
  localparam int IND_BIT        = 0;
  // flash command bytes and addresses
  localparam logic [22:0] UNLOCK_A1   = 23'h000555;
  localparam logic [22:0] UNLOCK_A2   = 23'h0002AA;
  localparam logic [15:0] UNLOCK_D1   = 16'h00AA;
  localparam logic [15:0] UNLOCK_D2   = 16'h0055;
  localparam logic [15:0] CODE_LOCKREG = 16'h0040;
  localparam logic [15:0] CODE_PWD     = 16'h0060;
  localparam logic [15:0] CODE_PPB     = 16'h00C0;
  localparam logic [15:0] CODE_MASTER  = 16'h00F1;
  localparam logic [15:0] CODE_PROG    = 16'h00A0;
  localparam logic [15:0] CODE_EXIT1   = 16'h0090;
  localparam logic [15:0] CODE_EXIT2   = 16'h0000;
  localparam logic [15:0] CODE_ERASE1  = 16'h0080;
  localparam logic [15:0] CODE_ERASE2  = 16'h0030;
  localparam logic [15:0] CODE_PROTECT = 16'h0000;
  localparam logic [15:0] CODE_UNLK1   = 16'h0025;
  localparam logic [15:0] CODE_UNLK2   = 16'h0003;
  localparam logic [15:0] CODE_UNLK3   = 16'h0029;
  localparam logic [22:0] ADDR_ZERO    = 23'h000000;
  // bus cycle phase lengths in clock cycles
  localparam int SETUP_CYC  = 2;
  localparam int STROBE_CYC = 5;
  localparam int HOLD_CYC   = 2;

  typedef enum logic [3:0] {
    CMD_ENTER_LOCKREG = 4'h0,
    CMD_READ_LOCKREG  = 4'h1,
    CMD_PROG_LOCKREG  = 4'h2,
    CMD_EXIT          = 4'h3,
    CMD_ENTER_PWD     = 4'h4,
    CMD_READ_PWD      = 4'h5,
    CMD_UNLOCK_PWD    = 4'h6,
    CMD_ENTER_PPB     = 4'h7,
    CMD_PPB_PROG      = 4'h8,
    CMD_PPB_ERASE     = 4'h9,
    CMD_MASTER_SET    = 4'hA,
    CMD_STATUS_READ   = 4'hB
  } fbpcCmd_t;

  typedef struct packed {
    logic              isRead;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fbpcCycle_t;

  typedef struct packed {
    logic              ceN;
    logic              oeN;
    logic              weN;
    logic              dqOe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dqOut;
  } fbpcPins_t;
endpackage

// [core/fbpc_bus_cycle.sv]
/*
  One asynchronous flash bus cycle, read or write, on the flash pins.
  Assumes flash inputs are synchronous to clk and that phase lengths
  meet the part's timing at the clk rate.
*/
`timescale 1ns/1ps
`default_nettype none
module fbpc_bus_cycle #(
  parameter int SETUP  = fbpc_pkg::SETUP_CYC,
  parameter int STROBE = fbpc_pkg::STROBE_CYC,
  parameter int HOLD   = fbpc_pkg::HOLD_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  start,
  input  wire fbpc_pkg::fbpcCycle_t  req,
  input  wire logic [15:0]           dqIn,
  output var  fbpc_pkg::fbpcPins_t   pins,
  output logic                       done,
  output logic [15:0]                rdData
);
  typedef enum logic [1:0] {
    BC_IDLE   = 2'b00,
    BC_SETUP  = 2'b01,
    BC_STROBE = 2'b10,
    BC_HOLD   = 2'b11
  } fbpcBcState_t;

  initial begin
    if (SETUP < 1 || STROBE < 1 || HOLD < 1 || STROBE > 255 ||
        SETUP > 255 || HOLD > 255)
      $error("fbpc_bus_cycle: phase lengths must be 1..255");
  end

  fbpcBcState_t state_q;
  logic [7:0]   cnt_q;
  logic         isRead_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q  <= BC_IDLE;
      cnt_q    <= 8'h00;
      isRead_q <= 1'b0;
      done     <= 1'b0;
      rdData   <= 16'h0000;
      pins     <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, dqOe: 1'b0,
                    addr: '0, dqOut: '0};
    end else begin
      done <= 1'b0;
      unique case (state_q)
        BC_IDLE: begin
          if (start) begin
            state_q    <= BC_SETUP;
            cnt_q      <= 8'(SETUP - 1);
            isRead_q   <= req.isRead;
            pins.ceN   <= 1'b0;
            pins.addr  <= req.addr;
            pins.dqOut <= req.data;
            pins.dqOe  <= ~req.isRead;
          end
        end
        BC_SETUP: begin
          if (cnt_q == 8'h00) begin
            state_q  <= BC_STROBE;
            cnt_q    <= 8'(STROBE - 1);
            pins.oeN <= ~isRead_q;
            pins.weN <= isRead_q;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        BC_STROBE: begin
          if (cnt_q == 8'h00) begin
            // data is taken at the end of the strobe, before oe rises
            if (isRead_q)
              rdData <= dqIn;
            state_q  <= BC_HOLD;
            cnt_q    <= 8'(HOLD - 1);
            pins.oeN <= 1'b1;
            pins.weN <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        BC_HOLD: begin
          if (cnt_q == 8'h00) begin
            state_q   <= BC_IDLE;
            pins.ceN  <= 1'b1;
            pins.dqOe <= 1'b0;
            done      <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [core/fbpc_host.sv]
/*
  Host controller that issues block protection command sequences to a
  parallel NOR flash, taking orders over APB.
  Assumes an APB master on clk and a flash whose inputs are synchronous.
*/
// Operation
// - host programs persistent bits before master lock; fbpc_host issues CMD_MASTER_SET whenever ordered, without checking
// - host uses master lock for permanent guard
// - AA/555, 55/2AA, 40/555 enters lock register
// - one read at 00 returns lock register
// - A0 then value programs lock register
// - 90 then 00 leaves command set
// - AA, 55, 60 enters password set
// - AA, 55, C0 enters persistent set
// - 80 then 30 erases all persistent bits
// - AA, 55, F1 sets master lock bit
`timescale 1ns/1ps
`default_nettype none
module fbpc_host (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [15:0]          dqIn,
  output var  fbpc_pkg::fbpcPins_t  flashPins
);
  typedef enum logic [1:0] {
    SQ_IDLE  = 2'b00,
    SQ_ISSUE = 2'b01,
    SQ_WAIT  = 2'b10
  } fbpcSeqState_t;

  fbpcSeqState_t        state_q;
  fbpc_pkg::fbpcCmd_t   cmd_q;
  logic [22:0]          addr_q;
  logic [15:0]          wdata_q;
  logic [63:0]          pw_q;
  logic [63:0]          rd_q;
  logic [2:0]           step_q;
  logic                 done_q;
  logic                 prot_q;
  logic                 err_q;
  logic                 cycStart_q;
  logic                 cycDone;
  logic [15:0]          cycData;
  fbpc_pkg::fbpcCycle_t cur;
  logic                 apbWr;
  logic                 startReq;

  // unlock prefix used by every command set entry
  function automatic fbpc_pkg::fbpcCycle_t entry(input logic [2:0] s,
                                                  input logic [15:0] code);
    fbpc_pkg::fbpcCycle_t c;
    c.isRead = 1'b0;
    c.addr   = fbpc_pkg::UNLOCK_A1;
    c.data   = code;
    if (s == 3'd0)
      c.data = fbpc_pkg::UNLOCK_D1;
    else if (s == 3'd1) begin
      c.addr = fbpc_pkg::UNLOCK_A2;
      c.data = fbpc_pkg::UNLOCK_D2;
    end
    return c;
  endfunction

  function automatic fbpc_pkg::fbpcCycle_t wr(input logic [22:0] a,
                                               input logic [15:0] d);
    return '{isRead: 1'b0, addr: a, data: d};
  endfunction

  function automatic fbpc_pkg::fbpcCycle_t rd(input logic [22:0] a);
    return '{isRead: 1'b1, addr: a, data: 16'h0000};
  endfunction

  // number of bus cycles minus one; codes above B are refused by legal
  function automatic logic [2:0] lastStep(input fbpc_pkg::fbpcCmd_t c);
    unique case (c)
      fbpc_pkg::CMD_ENTER_LOCKREG,
      fbpc_pkg::CMD_ENTER_PWD,
      fbpc_pkg::CMD_ENTER_PPB,
      fbpc_pkg::CMD_MASTER_SET:  return 3'd2;
      fbpc_pkg::CMD_READ_LOCKREG,
      fbpc_pkg::CMD_STATUS_READ: return 3'd0;
      fbpc_pkg::CMD_READ_PWD:    return 3'd3;
      fbpc_pkg::CMD_UNLOCK_PWD:  return 3'd6;
      default:                   return 3'd1;
    endcase
  endfunction

  function automatic logic legal(input logic [3:0] c);
    return c <= 4'hB;
  endfunction

  always_comb begin
    cur = wr(fbpc_pkg::ADDR_ZERO, 16'h0000);
    unique case (cmd_q)
      fbpc_pkg::CMD_ENTER_LOCKREG:
        cur = entry(step_q, fbpc_pkg::CODE_LOCKREG);
      fbpc_pkg::CMD_READ_LOCKREG:
        cur = rd(fbpc_pkg::ADDR_ZERO);
      fbpc_pkg::CMD_PROG_LOCKREG:
        cur = wr(addr_q, step_q == 3'd0 ? fbpc_pkg::CODE_PROG
                                        : wdata_q);
      fbpc_pkg::CMD_EXIT:
        cur = wr(addr_q, step_q == 3'd0 ? fbpc_pkg::CODE_EXIT1
                                        : fbpc_pkg::CODE_EXIT2);
      fbpc_pkg::CMD_ENTER_PWD:
        cur = entry(step_q, fbpc_pkg::CODE_PWD);
      fbpc_pkg::CMD_READ_PWD:
        cur = rd({20'h00000, step_q});
      fbpc_pkg::CMD_UNLOCK_PWD: begin
        unique case (step_q)
          3'd0:    cur = wr(fbpc_pkg::ADDR_ZERO, fbpc_pkg::CODE_UNLK1);
          3'd1:    cur = wr(fbpc_pkg::ADDR_ZERO, fbpc_pkg::CODE_UNLK2);
          3'd2:    cur = wr(23'h000000, pw_q[15:0]);
          3'd3:    cur = wr(23'h000001, pw_q[31:16]);
          3'd4:    cur = wr(23'h000002, pw_q[47:32]);
          3'd5:    cur = wr(23'h000003, pw_q[63:48]);
          default: cur = wr(fbpc_pkg::ADDR_ZERO, fbpc_pkg::CODE_UNLK3);
        endcase
      end
      fbpc_pkg::CMD_ENTER_PPB:
        cur = entry(step_q, fbpc_pkg::CODE_PPB);
      fbpc_pkg::CMD_PPB_PROG:
        // block address only on the second cycle
        cur = step_q == 3'd0 ? wr(fbpc_pkg::ADDR_ZERO, fbpc_pkg::CODE_PROG)
                             : wr(addr_q, fbpc_pkg::CODE_PROTECT);
      fbpc_pkg::CMD_PPB_ERASE:
        cur = wr(fbpc_pkg::ADDR_ZERO,
                 step_q == 3'd0 ? fbpc_pkg::CODE_ERASE1
                                : fbpc_pkg::CODE_ERASE2);
      fbpc_pkg::CMD_MASTER_SET:
        // irreversible: software must have set persistent bits first;
        cur = entry(step_q, fbpc_pkg::CODE_MASTER);
      fbpc_pkg::CMD_STATUS_READ:
        cur = rd(addr_q);
    endcase
  end

  assign apbWr    = psel & penable & pready & pwrite;
  assign startReq = apbWr && paddr == fbpc_pkg::REG_CTRL &&
                    pwdata[fbpc_pkg::CTRL_START_BIT];

  // apb slave: no wait states, pready from a flop
  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (psel && !penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      unique case (paddr)
        fbpc_pkg::REG_CTRL:   prdata <= {28'h0000000, cmd_q};
        fbpc_pkg::REG_ADDR:   prdata <= {9'h000, addr_q};
        fbpc_pkg::REG_WDATA:  prdata <= {16'h0000, wdata_q};
        fbpc_pkg::REG_PWLO:   prdata <= pw_q[31:0];
        fbpc_pkg::REG_PWHI:   prdata <= pw_q[63:32];
        fbpc_pkg::REG_STATUS: prdata <= {28'h0000000, err_q, prot_q,
                                         done_q, state_q != SQ_IDLE};
        fbpc_pkg::REG_RDLO:   prdata <= rd_q[31:0];
        fbpc_pkg::REG_RDHI:   prdata <= rd_q[63:32];
        default:              pslverr <= 1'b1;
      endcase
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // operand registers; frozen while a sequence runs
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_q  <= 23'h000000;
      wdata_q <= 16'h0000;
      pw_q    <= 64'h0000000000000000;
    end else if (apbWr && state_q == SQ_IDLE) begin
      unique case (paddr)
        fbpc_pkg::REG_ADDR:  addr_q     <= pwdata[22:0];
        fbpc_pkg::REG_WDATA: wdata_q    <= pwdata[15:0];
        fbpc_pkg::REG_PWLO:  pw_q[31:0] <= pwdata;
        fbpc_pkg::REG_PWHI:  pw_q[63:32] <= pwdata;
        default: ;
      endcase
    end
  end

  // sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q    <= SQ_IDLE;
      cmd_q      <= fbpc_pkg::CMD_EXIT;
      step_q     <= 3'd0;
      done_q     <= 1'b0;
      err_q      <= 1'b0;
      cycStart_q <= 1'b0;
    end else begin
      cycStart_q <= 1'b0;
      unique case (state_q)
        SQ_IDLE: begin
          if (startReq) begin
            done_q <= 1'b0;
            step_q <= 3'd0;
            if (legal(pwdata[3:0])) begin
              cmd_q      <= fbpc_pkg::fbpcCmd_t'(pwdata[3:0]);
              err_q      <= 1'b0;
              state_q    <= SQ_ISSUE;
            end else begin
              err_q  <= 1'b1;
              done_q <= 1'b1;
            end
          end
        end
        SQ_ISSUE: begin
          cycStart_q <= 1'b1;
          state_q    <= SQ_WAIT;
        end
        SQ_WAIT: begin
          if (cycDone) begin
            if (step_q == lastStep(cmd_q)) begin
              state_q <= SQ_IDLE;
              done_q  <= 1'b1;
            end else begin
              step_q  <= step_q + 3'd1;
              state_q <= SQ_ISSUE;
            end
          end
        end
        default: state_q <= SQ_IDLE;
      endcase
    end
  end

  // read capture: password words by step, indicator on line zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_q   <= 64'h0000000000000000;
      prot_q <= 1'b0;
    end else if (state_q == SQ_WAIT && cycDone && cur.isRead) begin
      rd_q[16*step_q[1:0] +: 16] <= cycData;
      // zero on line zero means protected
      prot_q <= ~cycData[fbpc_pkg::IND_BIT];
    end
  end

  fbpc_bus_cycle u_cycle (
    .clk    (clk),
    .reset  (reset),
    .start  (cycStart_q),
    .req    (cur),
    .dqIn   (dqIn),
    .pins   (flashPins),
    .done   (cycDone),
    .rdData (cycData)
  );
endmodule
`default_nettype wire

// [tb/fbpc_host_props.sv]
/*
  Checker of the APB handshake and flash pin timing of fbpc_host.
  Assumes default phase lengths 2/5/2 in the bus cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module fbpc_host_props (
  input wire logic                clk,
  input wire logic                reset,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [15:0]         dqIn,
  input wire fbpc_pkg::fbpcPins_t flashPins
);
  fbpc_pkg::fbpcPins_t p;
  assign p = flashPins;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_READY_AFTER_SETUP:
    assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  AST_READY_ONE_CYCLE:
    assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_ERR_WITH_READY:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_WRITE_DRIVES:
    assert property (!p.weN |-> p.dqOe)
    else $error("dq not driven in write");
  AST_READ_RELEASES:
    assert property (!p.oeN |-> !p.dqOe)
    else $error("dq driven in read");
  AST_WE_WIDTH:
    assert property ($fell(p.weN) |-> !p.weN [*5] ##1 p.weN)
    else $error("write strobe width");
  AST_OE_WIDTH:
    assert property ($fell(p.oeN) |-> !p.oeN [*5] ##1 p.oeN)
    else $error("read strobe width");
  AST_CE_LEADS_WE:
    assert property ($fell(p.weN) |-> !$past(p.ceN, 2))
    else $error("chip enable late");
  AST_ADDR_STANDS:
    assert property (!p.ceN && !$past(p.ceN) |->
                     $stable(p.addr) && $stable(p.dqOut))
    else $error("address or data moved in cycle");
  AST_CE_GAP:
    assert property ($rose(p.ceN) |-> p.ceN [*2])
    else $error("chip enable gap short");
endmodule
bind fbpc_host fbpc_host_props chk_u (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .dqIn(dqIn),
  .flashPins(flashPins));
`default_nettype wire

// [tb/fbpc_flash_model.sv]
/*
  Behavioural x16 flash on the far side of fbpc_host: protection bits,
  lock register, password and command decoding.
  Assumes pins change only after clk edges; a write lands as weN rises.
*/
`timescale 1ns/1ps
`default_nettype none
module fbpc_flash_model #(
  parameter logic [63:0] PASSWORD = 64'h0
) (
  input  wire logic                clk,
  input  wire fbpc_pkg::fbpcPins_t pins,
  output logic [15:0]              dqIn
);
  logic [38:0]  logQ[$];
  logic [127:0] persist_q = '1;
  logic [127:0] dyn_q     = ~128'h8;  // block 3 held by its dynamic bit
  logic         lockN_q   = 1'b1;  // no reset
  logic [15:0]  lockReg_q = 16'hFFFF;
  logic [15:0]  last_q    = 16'h0000;
  logic [63:0]  pw_q      = 64'h0;
  logic [1:0]   mode_q    = 2'd0;
  logic [1:0]   uStep_q   = 2'd0;
  logic [2:0]   pwStep_q  = 3'd0;
  logic [7:0]   pre_q     = 8'h00;
  logic         weN_q     = 1'b1;
  logic         pwOk_q    = 1'b0;
  logic [15:0]  rdVal;
  logic [6:0]   blk;
  logic [7:0]   d;
  assign blk = pins.addr[22:16];
  assign d   = pins.dqOut[7:0];
  always_comb begin
    case (mode_q)
      2'd1:    rdVal = lockReg_q;
      2'd2:    rdVal = PASSWORD[16*pins.addr[1:0] +: 16];
      default: rdVal = 16'(persist_q[blk] & dyn_q[blk]);
    endcase
  end
  // a released bus must not hold a stale copy of the last word
  assign dqIn = (!pins.ceN && !pins.oeN) ? rdVal : ~last_q;
  always_ff @(posedge clk) begin
    weN_q <= pins.weN;
    if (!pins.ceN && !pins.oeN)
      last_q <= rdVal;
    if (pins.weN && !weN_q) begin
      logQ.push_back({pins.addr, pins.dqOut});
      pre_q <= d;
      if (pwStep_q != 3'd0) begin
        if (pwStep_q == 3'd6 || (pwStep_q == 3'd1 && d != 8'h03))
          pwStep_q <= 3'd0;
        else
          pwStep_q <= pwStep_q + 3'd1;
        if (pwStep_q >= 3'd2 && pwStep_q <= 3'd5)
          pw_q[16*(pwStep_q-3'd2) +: 16] <= pins.dqOut;
        if (pwStep_q == 3'd6)
          pwOk_q <= (d == 8'h29) && (pw_q == PASSWORD);
      end else if (d == 8'hAA && pins.addr[10:0] == 11'h555)
        uStep_q <= 2'd1;
      else if (uStep_q == 2'd1 && d == 8'h55 && pins.addr[10:0] == 11'h2AA)
        uStep_q <= 2'd2;
      else if (uStep_q == 2'd2 && pins.addr[10:0] == 11'h555) begin
        uStep_q <= 2'd0;
        case (d)
          8'h40:   mode_q <= 2'd1;
          8'h60:   mode_q <= 2'd2;
          8'hC0:   mode_q <= 2'd3;
          8'hF1:   lockN_q <= 1'b0;
          default: ;
        endcase
      end else begin
        uStep_q <= 2'd0;
        if (pre_q == 8'hA0 && mode_q == 2'd1)
          lockReg_q <= pins.dqOut;
        if (pre_q == 8'hA0 && mode_q == 2'd3 && d == 8'h00)
          persist_q[blk] <= 1'b0;
        // erase ignored once locked; programming still lands
        if (pre_q == 8'h80 && mode_q == 2'd3 && d == 8'h30 && lockN_q)
          persist_q <= '1;
        if (pre_q == 8'h90 && d == 8'h00)
          mode_q <= 2'd0;
        if (mode_q == 2'd2 && d == 8'h25)
          pwStep_q <= 3'd1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
/*
  Self-checking bench for fbpc_host driven over APB.
  Assumes fbpc_flash_model on the flash pins and default phase lengths.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [63:0] PW = 64'h4D3C_2B1A_6F5E_1357;
  logic                clk = 1'b0;
  logic                reset = 1'b1;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0000_0000;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic [15:0]         dqIn;
  fbpc_pkg::fbpcPins_t flashPins;
  logic [31:0]         rd;
  logic                err;
  int                  fails = 0;
  int                  n_tests = 0;
  int                  cyc = 0;
  always #5 clk = ~clk;
  fbpc_host dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dqIn(dqIn), .flashPins(flashPins));
  fbpc_flash_model #(.PASSWORD(PW)) fm_u (.clk(clk), .pins(flashPins),
    .dqIn(dqIn));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [38:0] seen, input logic [38:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] c);
    int k;
    fm_u.logQ.delete();
    apb(1'b1, fbpc_pkg::REG_CTRL, {23'h0, 1'b1, 4'h0, c});
    k = 0;
    do begin
      apb(1'b0, fbpc_pkg::REG_STATUS, 32'h0000_0000);
      k++;
    end while (rd[fbpc_pkg::ST_DONE_BIT] !== 1'b1 && k < 200);
    // a sequence that never finishes counts as a mismatch
    if (rd[fbpc_pkg::ST_DONE_BIT] !== 1'b1) fails++;
  endtask
  task automatic expW(input logic [22:0] a, input logic [15:0] v);
    chk(fm_u.logQ.pop_front(), {a, v});
  endtask
  task automatic expD(input logic [15:0] v);
    logic [38:0] x;
    x = fm_u.logQ.pop_front();
    chk(x[15:0], v);
  endtask
  task automatic enter(input logic [3:0] c, input logic [15:0] code);
    cmd(c);
    expW(fbpc_pkg::UNLOCK_A1, fbpc_pkg::UNLOCK_D1);
    expW(fbpc_pkg::UNLOCK_A2, fbpc_pkg::UNLOCK_D2);
    expW(fbpc_pkg::UNLOCK_A1, code);
  endtask
  task automatic ex();
    cmd(4'h3);
    expD(16'h0090);
    expD(16'h0000);
  endtask
  task automatic st(input logic [31:0] a, input logic e);
    apb(1'b1, fbpc_pkg::REG_ADDR, a);
    cmd(4'hB);
    chk(rd[fbpc_pkg::ST_PROT_BIT], e);
  endtask
  task automatic pg(input logic [31:0] a);
    apb(1'b1, fbpc_pkg::REG_ADDR, a);
    cmd(4'h8);
    expD(16'h00A0);
    expW(a[22:0], 16'h0000);
  endtask
  task automatic er();
    cmd(4'h9);
    expD(16'h0080);
    expD(16'h0030);
  endtask
  task automatic t_regs();
    apb(1'b0, fbpc_pkg::REG_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 8'h24, 32'hFFFF_FFFF);
    chk(err, 1'b1);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({err, rd}, {1'b1, 32'h0000_0000});
    cmd(4'hC);
    chk(rd[fbpc_pkg::ST_ERR_BIT], 1'b1);
    chk(fm_u.logQ.size(), 0);
  endtask
  task automatic t_lockreg();
    enter(4'h0, 16'h0040);
    apb(1'b1, fbpc_pkg::REG_WDATA, 32'h0000_0006);
    cmd(4'h2);
    expD(16'h00A0);
    expD(16'h0006);
    cmd(4'h1);
    apb(1'b0, fbpc_pkg::REG_RDLO, 32'h0000_0000);
    chk(rd[15:0], 16'h0006);
    ex();
  endtask
  task automatic t_pwd();
    enter(4'h4, 16'h0060);
    cmd(4'h5);
    apb(1'b0, fbpc_pkg::REG_RDLO, 32'h0000_0000);
    chk(rd, PW[31:0]);
    apb(1'b0, fbpc_pkg::REG_RDHI, 32'h0000_0000);
    chk(rd, PW[63:32]);
    apb(1'b1, fbpc_pkg::REG_PWLO, PW[31:0]);
    apb(1'b1, fbpc_pkg::REG_PWHI, PW[63:32]);
    cmd(4'h6);
    expW(23'h0, 16'h0025);
    expW(23'h0, 16'h0003);
    for (int i = 0; i < 4; i++)
      expW(23'(i), PW[16*i +: 16]);
    expW(23'h0, 16'h0029);
    chk(fm_u.pwOk_q, 1'b1);
    ex();
  endtask
  task automatic t_protect();
    enter(4'h7, 16'h00C0);
    st(32'h0001_0000, 1'b0);
    st(32'h0003_0000, 1'b1);
    pg(32'h0001_0000);
    st(32'h0001_0000, 1'b1);
    er();
    st(32'h0001_0000, 1'b0);
    pg(32'h0001_0000);
    enter(4'hA, 16'h00F1);
    st(32'h0002_0000, 1'b0);
    er();
    st(32'h0001_0000, 1'b1);
    pg(32'h0002_0000);
    st(32'h0002_0000, 1'b1);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    st(32'h0001_0000, 1'b1);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_lockreg();
    t_pwd();
    t_protect();
    summarize();
  end
endmodule
`default_nettype wire
